/* design/pepfs_pkg.sv */
package pepfs_pkg;

	// register map
	localparam logic [7:0]  PEPFS_ASSIGN_OFFSET = 8'h00;
	localparam logic [15:0] PEPFS_ASSIGN_RESET  = 16'h0000;
	localparam logic [15:0] PEPFS_WRITE_MASK    = 16'h77d7;

	// field positions of port_e_pin_assignment
	localparam int PEPFS_SINT_LSB  = 12;
	localparam int PEPFS_CFG_LSB   = 9;
	localparam int PEPFS_PIPE_BIT  = 8;
	localparam int PEPFS_WE_BIT    = 7;
	localparam int PEPFS_ADDRESS_MULTIPLEX_CONTROL_BIT  = 6;
	localparam int PEPFS_FLAG_BIT  = 5;
	localparam int PEPFS_CAS23_BIT = 4;
	localparam int PEPFS_CAS01_BIT = 2;
	localparam int PEPFS_CS7_BIT   = 1;
	localparam int PEPFS_AUTOVECTOR_INPUT_BIT  = 0;

	// slave_irq_output_style codes
	localparam logic [2:0] PEPFS_SINT_DEFAULT  = 3'h0;
	localparam logic [2:0] PEPFS_SINT_IRQ_REQ  = 3'h2;
	localparam logic [2:0] PEPFS_SINT_IRQ_LVL  = 3'h3;
	localparam logic [2:0] PEPFS_SINT_PAR_REQ  = 3'h4;
	localparam logic [2:0] PEPFS_SINT_PAR_LVL  = 3'h5;

	// config_pin_role_select codes
	localparam logic [1:0] PEPFS_CFG_BUS_CLEAR = 2'h2;
	localparam logic [1:0] PEPFS_CFG_ROW2_DUP  = 2'h3;

	// synchronised pin inputs
	localparam int PEPFS_SYNC_W = 14;

endpackage

/* design/pepfs_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module pepfs_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// asynchronous levels in, synchronised levels out
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} pepfs_sync_s;

	pepfs_sync_s s;
	pepfs_sync_s next_s;

	always_comb begin
		next_s        = s;
		next_s.meta   = async_in;
		next_s.stable = s.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_out = s.stable;

endmodule

`default_nettype wire

/* design/pepfs_port_e_pin_function_select.sv */
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - shared address/write-strobe pins stay three-stated until low byte first written
// - parity pins stay three-stated until low byte first written
// - bit 5 reads 0 before the first low-byte write, 1 after
// - register may be read or written at any time, no locking
// - bits 14-12 pick irq output style in slave mode only; 000 default, 001/110/111 reserved
// - style 010 single request on level-1 pin; 011 level code on 6/4/1
// - style 100 single request on parity pin 2; 101 code on parity 0..2
// - bits 10-9: config input, bus-clear output or row strobe 2 duplicate
// - bit 8: instruction pipe or bus-clear input, else row strobe 1 duplicate
// - bit 7: upper address bits 31-28 or four byte write strobes
// - bit 6: output-enable strobe or address multiplex control
// - bit 4: column strobes 2,3 or interrupt acknowledges 3,6
// - bit 2: column strobes 0,1 or interrupt acknowledges 1,2
// - bit 1: chip select 7 or interrupt acknowledge 7
// - bit 0: autovector in (out in slave mode) or interrupt acknowledge 5
// - bits 15, 11 and 3 are reserved, read zero, do nothing
module pepfs_port_e_pin_function_select (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic        pready,
	output var  logic [31:0] prdata,
	output var  logic        pslverr,
	// operating mode from core logic
	input  wire logic        slave_mode,
	// internal functions to be routed
	input  wire logic [3:0]  column_strobes_n,
	input  wire logic        int_ack_level_1_n,
	input  wire logic        int_ack_level_2_n,
	input  wire logic        int_ack_level_3_n,
	input  wire logic        int_ack_level_5_n,
	input  wire logic        int_ack_level_6_n,
	input  wire logic        int_ack_level_7_n,
	input  wire logic        chip_select_seven_n,
	input  wire logic        output_enable_n,
	input  wire logic        address_multiplex_control,
	input  wire logic [3:0]  byte_write_strobes_n,
	input  wire logic [3:0]  addr_hi_out,
	input  wire logic        addr_hi_drive,
	input  wire logic [3:0]  parity_out,
	input  wire logic        parity_drive,
	input  wire logic        autovector_output_n,
	input  wire logic        single_request_output_n,
	input  wire logic [2:0]  encoded_level_outputs_n,
	input  wire logic        bus_clear_output_n,
	input  wire logic        row_strobe_1_duplicate_n,
	input  wire logic        row_strobe_2_duplicate_n,
	input  wire logic        instruction_pipe_out_n,
	// column strobe / acknowledge pins
	output var  logic [1:0]  cas01_pin_o,
	output var  logic [1:0]  cas23_pin_o,
	output var  logic        cs7_pin_o,
	output var  logic        oe_address_multiplex_control_pin_o,
	// autovector pin
	input  wire logic        autovector_input_pin_i,
	output var  logic        autovector_input_pin_o,
	output var  logic        autovector_input_pin_oe,
	// upper address / byte write strobe pins
	input  wire logic [3:0]  addr_we_pin_i,
	output var  logic [3:0]  addr_we_pin_o,
	output var  logic [3:0]  addr_we_pin_oe,
	// parity pins
	input  wire logic [3:0]  parity_pins_i,
	output var  logic [3:0]  parity_pins_o,
	output var  logic [3:0]  parity_pins_oe,
	// request pins: [0] level 1, [1] level 4, [2] level 6
	input  wire logic [2:0]  irq_pins_i,
	output var  logic [2:0]  irq_pins_o,
	output var  logic [2:0]  irq_pins_oe,
	// configuration pin
	input  wire logic        config_pin_i,
	output var  logic        config_pin_o,
	output var  logic        config_pin_oe,
	// instruction pipe pin
	input  wire logic        pipe_pin_i,
	output var  logic        pipe_pin_o,
	output var  logic        pipe_pin_oe,
	// synchronised pin levels to core logic
	output var  logic        autovector_input_n,
	output var  logic        boot_config_input,
	output var  logic        bus_clear_input_n,
	output var  logic [3:0]  addr_hi_in,
	output var  logic [3:0]  parity_in,
	output var  logic [2:0]  irq_in_n,
	// written flag for core logic
	output var  logic        low_byte_written_flag
);
	import pepfs_pkg::*;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [15:0] port_e_pin_assignment;
		logic [1:0]  cas01;
		logic [1:0]  cas23;
		logic        cs7;
		logic        oe_address_multiplex_control;
		logic        autovector_input_o;
		logic        autovector_input_oe;
		logic [3:0]  addr_we_o;
		logic [3:0]  addr_we_oe;
		logic [3:0]  par_o;
		logic [3:0]  par_oe;
		logic [2:0]  irq_o;
		logic [2:0]  irq_oe;
		logic        cfg_o;
		logic        cfg_oe;
		logic        pipe_o;
		logic        pipe_oe;
	} pepfs_state_s;

	pepfs_state_s s;
	pepfs_state_s next_s;

	logic [PEPFS_SYNC_W-1:0] sync_q;

	pepfs_sync #(
		.W (PEPFS_SYNC_W)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({autovector_input_pin_i, config_pin_i, pipe_pin_i, addr_we_pin_i,
			parity_pins_i, irq_pins_i}),
		.sync_out (sync_q)
	);

	logic        acc;
	logic        hit;
	logic [15:0] r;
	logic        flag;
	logic [2:0]  sint;
	logic [1:0]  cfg;

	always_comb begin
		next_s = s;
		r      = s.port_e_pin_assignment;
		flag   = r[PEPFS_FLAG_BIT];
		sint   = slave_mode ? r[PEPFS_SINT_LSB +: 3] : PEPFS_SINT_DEFAULT;
		cfg    = r[PEPFS_CFG_LSB +: 2];
		acc    = psel && penable;
		hit    = (paddr == PEPFS_ASSIGN_OFFSET);

		// one wait state, then completion; accepted at any time
		next_s.pready  = acc && !s.pready;
		next_s.pslverr = acc && !s.pready && !hit;
		next_s.prdata  = 32'h0000_0000;
		if (acc && !s.pready && hit && !pwrite) begin
			next_s.prdata = {16'h0000, r};
		end
		if (acc && s.pready && pwrite && hit) begin
			if (pstrb[0]) begin
				next_s.port_e_pin_assignment[7:0] =
					pwdata[7:0] & PEPFS_WRITE_MASK[7:0];
				next_s.port_e_pin_assignment[PEPFS_FLAG_BIT] = 1'b1;
			end
			if (pstrb[1]) begin
				next_s.port_e_pin_assignment[15:8] =
					pwdata[15:8] & PEPFS_WRITE_MASK[15:8];
			end
		end

		// column strobes or acknowledges
		next_s.cas01 = r[PEPFS_CAS01_BIT] ? {int_ack_level_2_n, int_ack_level_1_n}
			: column_strobes_n[1:0];
		next_s.cas23 = r[PEPFS_CAS23_BIT] ? {int_ack_level_6_n, int_ack_level_3_n}
			: column_strobes_n[3:2];
		next_s.cs7 = r[PEPFS_CS7_BIT] ? int_ack_level_7_n
			: chip_select_seven_n;
		next_s.oe_address_multiplex_control = r[PEPFS_ADDRESS_MULTIPLEX_CONTROL_BIT] ? address_multiplex_control
			: output_enable_n;

		// autovector pin
		if (r[PEPFS_AUTOVECTOR_INPUT_BIT]) begin
			next_s.autovector_input_o  = int_ack_level_5_n;
			next_s.autovector_input_oe = 1'b1;
		end else if (slave_mode) begin
			next_s.autovector_input_o  = autovector_output_n;
			next_s.autovector_input_oe = 1'b1;
		end else begin
			next_s.autovector_input_o  = 1'b1;
			next_s.autovector_input_oe = 1'b0;
		end

		// upper address or byte write strobes, held off until written
		if (r[PEPFS_WE_BIT]) begin
			next_s.addr_we_o  = byte_write_strobes_n;
			next_s.addr_we_oe = 4'hf;
		end else begin
			next_s.addr_we_o  = addr_hi_out;
			next_s.addr_we_oe = {4{addr_hi_drive}};
		end
		if (!flag) begin
			next_s.addr_we_oe = 4'h0;
		end

		// parity pins, or request styles on them
		next_s.par_o  = parity_out;
		next_s.par_oe = {4{parity_drive}};
		if (sint == PEPFS_SINT_PAR_REQ) begin
			next_s.par_o[2]  = single_request_output_n;
			next_s.par_oe[2] = 1'b1;
		end else if (sint == PEPFS_SINT_PAR_LVL) begin
			next_s.par_o[2:0] = {encoded_level_outputs_n[0],
				encoded_level_outputs_n[1], encoded_level_outputs_n[2]};
			next_s.par_oe[2:0] = 3'h7;
		end
		if (!flag) begin
			next_s.par_oe = 4'h0;
		end

		// request pins; reserved styles behave as default
		next_s.irq_o  = 3'h7;
		next_s.irq_oe = 3'h0;
		if (sint == PEPFS_SINT_IRQ_REQ) begin
			next_s.irq_o[0]  = single_request_output_n;
			next_s.irq_oe[0] = 1'b1;
		end else if (sint == PEPFS_SINT_IRQ_LVL) begin
			next_s.irq_o  = encoded_level_outputs_n;
			next_s.irq_oe = 3'h7;
		end

		// configuration pin role
		if (cfg == PEPFS_CFG_BUS_CLEAR) begin
			next_s.cfg_o  = bus_clear_output_n;
			next_s.cfg_oe = 1'b1;
		end else if (cfg == PEPFS_CFG_ROW2_DUP) begin
			next_s.cfg_o  = row_strobe_2_duplicate_n;
			next_s.cfg_oe = 1'b1;
		end else begin
			next_s.cfg_o  = 1'b1;
			next_s.cfg_oe = 1'b0;
		end

		// instruction pipe pin
		if (r[PEPFS_PIPE_BIT]) begin
			next_s.pipe_o  = row_strobe_1_duplicate_n;
			next_s.pipe_oe = 1'b1;
		end else if (slave_mode) begin
			next_s.pipe_o  = 1'b1;
			next_s.pipe_oe = 1'b0;
		end else begin
			next_s.pipe_o  = instruction_pipe_out_n;
			next_s.pipe_oe = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s                       <= '0;
			s.port_e_pin_assignment <= PEPFS_ASSIGN_RESET;
			s.prdata                <= 32'h0000_0000;
			s.cas01                 <= 2'h3;
			s.cas23                 <= 2'h3;
			s.cs7                   <= 1'b1;
			s.oe_address_multiplex_control               <= 1'b1;
			s.autovector_input_o                <= 1'b1;
			s.irq_o                 <= 3'h7;
			s.cfg_o                 <= 1'b1;
			s.pipe_o                <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign pready                = s.pready;
	assign prdata                = s.prdata;
	assign pslverr               = s.pslverr;
	assign cas01_pin_o           = s.cas01;
	assign cas23_pin_o           = s.cas23;
	assign cs7_pin_o             = s.cs7;
	assign oe_address_multiplex_control_pin_o         = s.oe_address_multiplex_control;
	assign autovector_input_pin_o            = s.autovector_input_o;
	assign autovector_input_pin_oe           = s.autovector_input_oe;
	assign addr_we_pin_o         = s.addr_we_o;
	assign addr_we_pin_oe        = s.addr_we_oe;
	assign parity_pins_o         = s.par_o;
	assign parity_pins_oe        = s.par_oe;
	assign irq_pins_o            = s.irq_o;
	assign irq_pins_oe           = s.irq_oe;
	assign config_pin_o          = s.cfg_o;
	assign config_pin_oe         = s.cfg_oe;
	assign pipe_pin_o            = s.pipe_o;
	assign pipe_pin_oe           = s.pipe_oe;
	assign low_byte_written_flag = s.port_e_pin_assignment[PEPFS_FLAG_BIT];

	// synchroniser outputs are flip-flops already
	assign autovector_input_n = sync_q[13];
	assign boot_config_input  = sync_q[12];
	assign bus_clear_input_n  = sync_q[11];
	assign addr_hi_in         = sync_q[10:7];
	assign parity_in          = sync_q[6:3];
	assign irq_in_n           = sync_q[2:0];

endmodule

`default_nettype wire

/* verification/pepfs_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module pepfs_asserts (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// held pins and flag
	input wire logic [3:0]  addr_we_pin_oe,
	input wire logic [3:0]  parity_pins_oe,
	input wire logic        low_byte_written_flag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	a_one_wait: assert property (s_wait |=> s_done)
		else $error("access not answered after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_err_addr: assert property (pready |-> pslverr == (paddr != 8'h00))
		else $error("error response does not match address");
	a_flag_set: assert property (s_done and (pwrite && pstrb[0] && paddr == 8'h00)
		|=> low_byte_written_flag)
		else $error("written flag not set by low byte write");
	a_flag_hold: assert property (low_byte_written_flag |=> low_byte_written_flag)
		else $error("written flag dropped without reset");
	a_flag_cause: assert property ($rose(low_byte_written_flag)
		|-> $past(pready) && $past(pwrite) && $past(pstrb[0]) && $past(paddr) == 8'h00)
		else $error("written flag rose without low byte write");
	a_we_hiz: assert property (!low_byte_written_flag |-> addr_we_pin_oe == 4'h0)
		else $error("address pins driven before low byte write");
	a_par_hiz: assert property (!low_byte_written_flag |-> parity_pins_oe == 4'h0)
		else $error("parity pins driven before low byte write");
	a_rd_fields: assert property (pready && !pwrite && !pslverr |-> prdata[31:16] == 16'h0
		&& !prdata[15] && !prdata[11] && !prdata[3]
		&& prdata[5] == low_byte_written_flag)
		else $error("read data reserved bits or flag wrong");
endmodule
bind pepfs_port_e_pin_function_select pepfs_asserts u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pstrb, .pready, .prdata, .pslverr, .addr_we_pin_oe, .parity_pins_oe,
	.low_byte_written_flag);
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, slave_mode, e;
	logic        int_ack_level_1_n, int_ack_level_2_n, int_ack_level_3_n, int_ack_level_5_n;
	logic        int_ack_level_6_n, int_ack_level_7_n, chip_select_seven_n, output_enable_n;
	logic        address_multiplex_control, addr_hi_drive, parity_drive, autovector_output_n;
	logic        single_request_output_n, bus_clear_output_n, row_strobe_1_duplicate_n;
	logic        row_strobe_2_duplicate_n, instruction_pipe_out_n, autovector_input_pin_i, config_pin_i;
	logic        pipe_pin_i, pready, pslverr, cs7_pin_o, oe_address_multiplex_control_pin_o, autovector_input_pin_o, autovector_input_pin_oe;
	logic        config_pin_o, config_pin_oe, pipe_pin_o, pipe_pin_oe, autovector_input_n;
	logic        boot_config_input, bus_clear_input_n, low_byte_written_flag;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0]  cas01_pin_o, cas23_pin_o;
	logic [3:0]  pstrb, column_strobes_n, byte_write_strobes_n, addr_hi_out, parity_out;
	logic [3:0]  addr_we_pin_i, addr_we_pin_o, addr_we_pin_oe, parity_pins_i, parity_pins_o;
	logic [3:0]  parity_pins_oe, addr_hi_in, parity_in;
	logic [2:0]  encoded_level_outputs_n, irq_pins_i, irq_pins_o, irq_pins_oe, irq_in_n;
	int          mismatches, checked;
	pepfs_port_e_pin_function_select uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .pready, .prdata, .pslverr, .slave_mode, .column_strobes_n,
		.int_ack_level_1_n, .int_ack_level_2_n, .int_ack_level_3_n, .int_ack_level_5_n,
		.int_ack_level_6_n, .int_ack_level_7_n, .chip_select_seven_n, .output_enable_n,
		.address_multiplex_control, .byte_write_strobes_n, .addr_hi_out, .addr_hi_drive,
		.parity_out, .parity_drive, .autovector_output_n, .single_request_output_n,
		.encoded_level_outputs_n, .bus_clear_output_n, .row_strobe_1_duplicate_n,
		.row_strobe_2_duplicate_n, .instruction_pipe_out_n, .cas01_pin_o, .cas23_pin_o,
		.cs7_pin_o, .oe_address_multiplex_control_pin_o, .autovector_input_pin_i, .autovector_input_pin_o, .autovector_input_pin_oe, .addr_we_pin_i,
		.addr_we_pin_o, .addr_we_pin_oe, .parity_pins_i, .parity_pins_o, .parity_pins_oe,
		.irq_pins_i, .irq_pins_o, .irq_pins_oe, .config_pin_i, .config_pin_o, .config_pin_oe,
		.pipe_pin_i, .pipe_pin_o, .pipe_pin_oe, .autovector_input_n, .boot_config_input,
		.bus_clear_input_n, .addr_hi_in, .parity_in, .irq_in_n, .low_byte_written_flag);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task stop_test;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer, entered just after a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for pready; if it never rises, only the bench timeout ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next call never reassigns psel in this step
		@(posedge pclk);
	endtask
	task rd(input logic [31:0] x);
		apb(1'b0, 8'h00, 32'h0, 4'h0);
		chk(r, x);
	endtask
	task wr(input logic [15:0] d, input logic [3:0] s);
		apb(1'b1, 8'h00, {16'h0, d}, s);
		cyc(3);
	endtask
	task t_before_low;
		chk(parity_pins_oe, 4'h0);
		rd(32'h0);
		wr(16'h2300, 4'h2);
		rd(32'h2300);
		chk(addr_we_pin_oe, 4'h0);
		apb(1'b1, 8'h04, 32'hffffffff, 4'hf);
		chk(e, 1'b1);
		rd(32'h2300);
		chk(addr_hi_in, 4'h9);
		chk(irq_in_n, 3'h5);
		chk({autovector_input_n, boot_config_input, bus_clear_input_n, parity_in}, 7'h76);
	endtask
	task t_low_routes;
		wr(16'h00ff, 4'h1);
		rd(32'h23f7);
		chk({addr_we_pin_o, addr_we_pin_oe}, 8'h5f);
		chk({parity_pins_o, parity_pins_oe}, 8'hcf);
		chk({cas23_pin_o, cas01_pin_o, cs7_pin_o, oe_address_multiplex_control_pin_o}, 6'h00);
		chk({autovector_input_pin_o, autovector_input_pin_oe, pipe_pin_o, pipe_pin_oe}, 4'h5);
		wr(16'h0000, 4'h3);
		rd(32'h20);
		chk({addr_we_pin_o, addr_we_pin_oe}, 8'haf);
		chk({cas23_pin_o, cas01_pin_o, cs7_pin_o, oe_address_multiplex_control_pin_o}, 6'h3f);
		chk({autovector_input_pin_oe, pipe_pin_o, pipe_pin_oe, config_pin_oe}, 4'h6);
	endtask
	task t_slave_styles;
		slave_mode <= 1'b1;
		wr(16'h3000, 4'h3);
		chk({irq_pins_o, irq_pins_oe}, 6'h37);
		chk({autovector_input_pin_o, autovector_input_pin_oe, pipe_pin_oe}, 3'h6);
		wr(16'h2000, 4'h2);
		chk({irq_pins_o[0], irq_pins_oe[0]}, 2'h1);
		wr(16'h5000, 4'h2);
		chk({parity_pins_o[2:0], parity_pins_oe[2:0]}, 6'h1f);
		wr(16'h4000, 4'h2);
		chk({parity_pins_o[2], parity_pins_oe[2]}, 2'h1);
		wr(16'h1000, 4'h2);
		chk({irq_pins_oe, parity_pins_o}, 7'h0c);
		slave_mode <= 1'b0;
		wr(16'h3000, 4'h2);
		chk(irq_pins_oe, 3'h0);
	endtask
	task t_cfg_and_reset;
		wr(16'h0400, 4'h2);
		chk({config_pin_o, config_pin_oe}, 2'h1);
		wr(16'h0600, 4'h2);
		chk({config_pin_o, config_pin_oe}, 2'h3);
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		cyc(1);
		rd(32'h0);
		chk({addr_we_pin_oe, low_byte_written_flag}, 5'h00);
	endtask
	initial begin
		{psel, penable, pwrite, slave_mode, presetn} = 5'h00;
		{int_ack_level_1_n, int_ack_level_2_n, int_ack_level_3_n, int_ack_level_5_n,
			int_ack_level_6_n, int_ack_level_7_n, address_multiplex_control,
			bus_clear_output_n, row_strobe_1_duplicate_n, single_request_output_n} = 10'h000;
		{chip_select_seven_n, output_enable_n, addr_hi_drive, parity_drive,
			autovector_output_n, row_strobe_2_duplicate_n, instruction_pipe_out_n,
			autovector_input_pin_i, config_pin_i, pipe_pin_i} = 10'h3ff;
		column_strobes_n = 4'hf;
		byte_write_strobes_n = 4'h5;
		addr_hi_out = 4'ha;
		parity_out = 4'hc;
		addr_we_pin_i = 4'h9;
		parity_pins_i = 4'h6;
		encoded_level_outputs_n = 3'h6;
		irq_pins_i = 3'h5;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
		mismatches = 0;
		checked = 0;
		cyc(2);
		presetn <= 1'b1;
		cyc(1);
		t_before_low;
		t_low_routes;
		t_slave_styles;
		t_cfg_and_reset;
		stop_test;
	end
	initial begin
		cyc(3000);
		mismatches++;
		stop_test;
	end
endmodule
`default_nettype wire
